//--- rtl/acpoc_pkg.sv
// Constants shared by the converter control logic.
// Assumes a 100 MHz control clock; all times are converted here.
package acpoc_pkg;
    // Register offsets
    localparam logic [12:0] ADR_POWER_MODE  = 13'h0008;
    localparam logic [12:0] ADR_CLOCK_CTRL  = 13'h0009;
    localparam logic [12:0] ADR_CLOCK_DIV   = 13'h000B;
    localparam logic [12:0] ADR_STATUS      = 13'h000D;
    localparam logic [12:0] ADR_OUTPUT_MODE = 13'h0014;
    localparam logic [12:0] ADR_NSR_CTRL    = 13'h003C;

    // Field positions
    localparam int POS_PWR_MODE   = 0;
    localparam int POS_DCS_EN     = 0;
    localparam int POS_DIV_RATIO  = 0;
    localparam int POS_FORMAT     = 0;
    localparam int POS_TRISTATE   = 4;
    localparam int POS_NSR_EN     = 0;
    localparam int POS_STS_LOCK   = 0;
    localparam int POS_STS_AWAKE  = 1;

    // Power mode codes
    localparam logic [1:0] PWR_NORMAL  = 2'h0;
    localparam logic [1:0] PWR_DOWN    = 2'h1;
    localparam logic [1:0] PWR_STANDBY = 2'h2;

    // Output formats
    localparam logic [1:0] FMT_OFFSET = 2'h0;
    localparam logic [1:0] FMT_TWOS   = 2'h1;
    localparam logic [1:0] FMT_GRAY   = 2'h2;

    // Reset values; divide field holds ratio minus one
    localparam logic [1:0] RST_PWR_MODE = 2'h0;
    localparam logic [2:0] RST_DIV      = 3'h0;
    localparam logic       RST_DCS_EN   = (RST_DIV != 3'h0);
    localparam logic [1:0] RST_FORMAT   = 2'h0;
    localparam logic       RST_TRISTATE = 1'b0;
    localparam logic       RST_NSR_EN   = 1'b0;

    // Latencies in sample clocks
    localparam int LAT_PLAIN = 10;
    localparam int LAT_NSR   = 13;
    localparam int LAT_OVR   = 10;

    // Timing
    localparam int CLK_MHZ          = 100;
    localparam int DCS_MIN_MHZ      = 40;
    localparam int DCS_MAX_PERIOD   = CLK_MHZ / DCS_MIN_MHZ;
    localparam int DCS_RELOCK_NS    = 1500;
    localparam int DCS_RELOCK_CYC   =
        (DCS_RELOCK_NS * CLK_MHZ + 999) / 1000;
    localparam int STBY_WAKE_NS     = 1000;
    localparam int STBY_WAKE_CYC    =
        (STBY_WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int PD_WAKE_SHIFT    = 4;
endpackage : acpoc_pkg

//--- rtl/acpoc_clk_div.sv
// Integer divider of the sampled converter clock.
// Assumes the clock input is already synchronous to i_mclk.
`timescale 1ns/1ps
module acpoc_clk_div #(
    parameter int RW = 3
) (
    // Clock and reset
    input  wire logic          i_mclk,
    input  wire logic          i_nrst,
    // Control
    input  wire logic          i_run,
    input  wire logic [RW-1:0] i_ratio_m1,
    input  wire logic          i_clk_in,
    // Divided clock
    output logic               o_tick,
    output logic               o_level
);
    logic          prev_q;
    logic [RW-1:0] cnt_q;
    logic          rise;
    logic          fall;

    assign rise   = i_clk_in & ~prev_q;
    assign fall   = ~i_clk_in & prev_q;
    assign o_tick = rise & i_run & (cnt_q == i_ratio_m1);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= i_clk_in;
        end
    end

    // Divide by one through eight
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= '0;
        end else if (!i_run) begin
            cnt_q <= '0;
        end else if (rise) begin
            cnt_q <= (cnt_q >= i_ratio_m1) ? '0 : cnt_q + 1'b1;
        end
    end

    // Raw duty: high for the high phase of one input cycle
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_level <= 1'b0;
        end else if (o_tick) begin
            o_level <= 1'b1;
        end else if (fall || !i_run) begin
            o_level <= 1'b0;
        end
    end
endmodule : acpoc_clk_div

//--- rtl/acpoc_pipe_delay.sv
// Sample delay line with a selectable output tap.
// Assumes one advance per internal sample clock tick.
`timescale 1ns/1ps
module acpoc_pipe_delay #(
    parameter int W     = 12,
    parameter int DEPTH = 13
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_nrst,
    // Shift control
    input  wire logic         i_adv,
    input  wire logic [3:0]   i_tap,
    input  wire logic [W-1:0] i_data,
    // Delayed data
    output logic [W-1:0]      o_data
);
    logic [W-1:0] stage_q [DEPTH];

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage_q[0] <= '0;
        end else if (i_adv) begin
            stage_q[0] <= i_data;
        end
    end

    for (genvar g = 1; g < DEPTH; g++) begin : g_stage
        always_ff @(posedge i_mclk or negedge i_nrst) begin
            if (!i_nrst) begin
                stage_q[g] <= '0;
            end else if (i_adv) begin
                stage_q[g] <= stage_q[g-1];
            end
        end
    end

    // Tap counts stages from one
    assign o_data = stage_q[i_tap - 4'h1];
endmodule : acpoc_pipe_delay

//--- rtl/acpoc_top.sv
// Clock, power and output control around a pipelined converter core.
// Assumes all pins are synchronous to i_mclk and the core result of
// each sample is presented on i_core_data at its sampling tick.
// Overview of operation
// - Sample clock is divided by an integer one through eight.
// - Duty stabilizer is enabled at reset unless divide ratio is one.
// - Enabled stabilizer regenerates the falling edge for half-period high.
// - Stabilizer loop need not run below about forty megahertz.
// - Unlocked stabilizer is bypassed; raw duty cycle is used.
// - Power mode 01 at 0x08 shuts reference, bias and clock.
// - Data, overrange and strobe outputs are high impedance in power-down.
// - Power mode 10 is standby with reference kept for fast wake.
// - Wake-up time grows with time spent powered down.
// - Output encoding is offset binary, two's complement or Gray.
// - Bit 4 of 0x14 forces data outputs to high impedance.
// - Latency is 10 samples, or 13 with noise shaping on.
// - Output data updates one clock before the internal clock rising edge.
// - Capture strobe is driven with the data for the receiver.
// - Overrange flag follows its sample by 10 clocks.
// - Each sample is captured on the divider tick, one clock before the internal clock rising edge.
`timescale 1ns/1ps
module acpoc_top #(
    parameter int DW          = 11,
    parameter int PW          = 16,
    parameter int RELOCK_CYC  = acpoc_pkg::DCS_RELOCK_CYC,
    parameter int MAX_PERIOD  = acpoc_pkg::DCS_MAX_PERIOD,
    parameter int STBY_CYC    = acpoc_pkg::STBY_WAKE_CYC
) (
    // Clock and reset
    input  wire logic          i_mclk,
    input  wire logic          i_nrst,
    // Sample clock and core results
    input  wire logic          i_sample_clk,
    input  wire logic [DW-1:0] i_core_data,
    input  wire logic          i_core_ovr,
    // Serial port
    input  wire logic          i_sclk,
    input  wire logic          i_csb_n,
    input  wire logic          i_sdio,
    output logic               o_sdio,
    output logic               o_sdio_oe,
    // Internal clock and power
    output logic               o_int_clk,
    output logic               o_ref_on,
    output logic               o_bias_on,
    output logic               o_awake,
    // Output port
    output logic [DW-1:0]      o_data,
    output logic               o_data_oe,
    output logic               o_ovr,
    output logic               o_ovr_oe,
    output logic               o_capture_strobe_out,
    output logic               o_strobe_oe
);
    typedef enum logic [3:0] {
        ACPOC_PWR_RUN  = 4'b0001,
        ACPOC_PWR_DOWN = 4'b0010,
        ACPOC_PWR_STBY = 4'b0100,
        ACPOC_PWR_WAKE = 4'b1000
    } acpoc_pwr_t;

    typedef enum logic [2:0] {
        ACPOC_SPI_INSTR = 3'b001,
        ACPOC_SPI_DATA  = 3'b010,
        ACPOC_SPI_DONE  = 3'b100
    } acpoc_spi_t;

    // Configuration registers
    logic [1:0]  pwr_mode_q;
    logic        dcs_en_q;
    logic [2:0]  div_q;
    logic [1:0]  fmt_q;
    logic        tri_q;
    logic        nsr_q;

    // Status
    logic        locked_q;
    acpoc_pwr_t  pwr_q;

    function automatic logic [7:0] reg_read(input logic [12:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            acpoc_pkg::ADR_POWER_MODE:
                r[acpoc_pkg::POS_PWR_MODE +: 2] = pwr_mode_q;
            acpoc_pkg::ADR_CLOCK_CTRL:
                r[acpoc_pkg::POS_DCS_EN] = dcs_en_q;
            acpoc_pkg::ADR_CLOCK_DIV:
                r[acpoc_pkg::POS_DIV_RATIO +: 3] = div_q;
            acpoc_pkg::ADR_STATUS: begin
                r[acpoc_pkg::POS_STS_LOCK]  = locked_q;
                r[acpoc_pkg::POS_STS_AWAKE] = (pwr_q == ACPOC_PWR_RUN);
            end
            acpoc_pkg::ADR_OUTPUT_MODE: begin
                r[acpoc_pkg::POS_FORMAT +: 2]  = fmt_q;
                r[acpoc_pkg::POS_TRISTATE]     = tri_q;
            end
            acpoc_pkg::ADR_NSR_CTRL:
                r[acpoc_pkg::POS_NSR_EN] = nsr_q;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : reg_read

    function automatic logic [DW-1:0] encode(input logic [DW-1:0] b,
                                             input logic [1:0] f);
        logic [DW-1:0] r;
        r = b;
        case (f)
            acpoc_pkg::FMT_TWOS: r = {~b[DW-1], b[DW-2:0]};
            acpoc_pkg::FMT_GRAY: r = b ^ (b >> 1);
            default:             r = b;
        endcase
        return r;
    endfunction : encode

    // Serial port, sampled as plain inputs
    acpoc_spi_t  spi_q;
    logic        sclk_q;
    logic [15:0] sh_q;
    logic [3:0]  bit_q;
    logic        rw_q;
    logic [1:0]  wlen_q;
    logic [12:0] addr_q;
    logic [1:0]  nbytes_q;
    logic [7:0]  rd_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [15:0] sh_next;
    logic        wr_stb;

    assign sclk_rise = i_sclk & ~sclk_q & ~i_csb_n;
    assign sclk_fall = ~i_sclk & sclk_q & ~i_csb_n;
    assign sh_next   = {sh_q[14:0], i_sdio};
    assign wr_stb    = sclk_rise & (spi_q == ACPOC_SPI_DATA) & ~rw_q
                     & (bit_q == 4'h7);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= i_sclk;
        end
    end

    // Frame: 16-bit instruction then data bytes
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            spi_q    <= ACPOC_SPI_INSTR;
            sh_q     <= 16'h0000;
            bit_q    <= 4'h0;
            rw_q     <= 1'b0;
            wlen_q   <= 2'h0;
            addr_q   <= 13'h0000;
            nbytes_q <= 2'h0;
            rd_q     <= 8'h00;
        end else if (i_csb_n) begin
            spi_q <= ACPOC_SPI_INSTR;
            bit_q <= 4'h0;
        end else if (sclk_rise) begin
            sh_q <= sh_next;
            case (spi_q)
                ACPOC_SPI_INSTR: begin
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == 4'hF) begin
                        rw_q     <= sh_next[15];
                        wlen_q   <= sh_next[14:13];
                        addr_q   <= sh_next[12:0];
                        nbytes_q <= 2'h0;
                        rd_q     <= reg_read(sh_next[12:0]);
                        bit_q    <= 4'h0;
                        spi_q    <= ACPOC_SPI_DATA;
                    end
                end
                ACPOC_SPI_DATA: begin
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == 4'h7) begin
                        bit_q    <= 4'h0;
                        addr_q   <= addr_q + 13'h0001;
                        nbytes_q <= nbytes_q + 2'h1;
                        rd_q     <= reg_read(addr_q + 13'h0001);
                        if (wlen_q != 2'h3 && nbytes_q == wlen_q) begin
                            spi_q <= ACPOC_SPI_DONE;
                        end
                    end
                end
                ACPOC_SPI_DONE: spi_q <= ACPOC_SPI_DONE;
                default:        spi_q <= ACPOC_SPI_INSTR;
            endcase
        end
    end

    // Read data driven on falling serial clock
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sdio    <= 1'b0;
            o_sdio_oe <= 1'b0;
        end else if (i_csb_n || !rw_q || spi_q != ACPOC_SPI_DATA) begin
            o_sdio_oe <= 1'b0;
        end else if (sclk_fall) begin
            o_sdio    <= rd_q[3'h7 - bit_q[2:0]];
            o_sdio_oe <= 1'b1;
        end
    end

    // Register writes
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr_mode_q <= acpoc_pkg::RST_PWR_MODE;
            dcs_en_q   <= acpoc_pkg::RST_DCS_EN;
            div_q      <= acpoc_pkg::RST_DIV;
            fmt_q      <= acpoc_pkg::RST_FORMAT;
            tri_q      <= acpoc_pkg::RST_TRISTATE;
            nsr_q      <= acpoc_pkg::RST_NSR_EN;
        end else if (wr_stb) begin
            case (addr_q)
                acpoc_pkg::ADR_POWER_MODE:
                    pwr_mode_q <= sh_next[acpoc_pkg::POS_PWR_MODE +: 2];
                acpoc_pkg::ADR_CLOCK_CTRL:
                    dcs_en_q <= sh_next[acpoc_pkg::POS_DCS_EN];
                acpoc_pkg::ADR_CLOCK_DIV:
                    div_q <= sh_next[acpoc_pkg::POS_DIV_RATIO +: 3];
                acpoc_pkg::ADR_OUTPUT_MODE: begin
                    fmt_q <= sh_next[acpoc_pkg::POS_FORMAT +: 2];
                    tri_q <= sh_next[acpoc_pkg::POS_TRISTATE];
                end
                acpoc_pkg::ADR_NSR_CTRL:
                    nsr_q <= sh_next[acpoc_pkg::POS_NSR_EN];
                default: tri_q <= tri_q;
            endcase
        end
    end

    // Power sequencing
    logic [PW-1:0] pd_time_q;
    logic [PW-1:0] wake_q;
    logic [PW-1:0] pd_wake;

    // Wake time scaled from time spent down, never below standby
    assign pd_wake = (pd_time_q >> acpoc_pkg::PD_WAKE_SHIFT)
                   > PW'(STBY_CYC)
                   ? pd_time_q >> acpoc_pkg::PD_WAKE_SHIFT
                   : PW'(STBY_CYC);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr_q     <= ACPOC_PWR_RUN;
            pd_time_q <= '0;
            wake_q    <= '0;
        end else begin
            case (pwr_q)
                ACPOC_PWR_RUN: begin
                    pd_time_q <= '0;
                    if (pwr_mode_q == acpoc_pkg::PWR_DOWN) begin
                        pwr_q <= ACPOC_PWR_DOWN;
                    end else if (pwr_mode_q == acpoc_pkg::PWR_STANDBY) begin
                        pwr_q <= ACPOC_PWR_STBY;
                    end
                end
                ACPOC_PWR_DOWN: begin
                    if (pd_time_q != '1) begin
                        pd_time_q <= pd_time_q + 1'b1;
                    end
                    if (pwr_mode_q == acpoc_pkg::PWR_STANDBY) begin
                        pwr_q <= ACPOC_PWR_STBY;
                    end else if (pwr_mode_q != acpoc_pkg::PWR_DOWN) begin
                        wake_q <= pd_wake;
                        pwr_q  <= ACPOC_PWR_WAKE;
                    end
                end
                ACPOC_PWR_STBY: begin
                    if (pwr_mode_q == acpoc_pkg::PWR_DOWN) begin
                        pwr_q <= ACPOC_PWR_DOWN;
                    end else if (pwr_mode_q != acpoc_pkg::PWR_STANDBY) begin
                        wake_q <= PW'(STBY_CYC);
                        pwr_q  <= ACPOC_PWR_WAKE;
                    end
                end
                ACPOC_PWR_WAKE: begin
                    wake_q <= wake_q - 1'b1;
                    if (pwr_mode_q == acpoc_pkg::PWR_DOWN) begin
                        pwr_q <= ACPOC_PWR_DOWN;
                    end else if (wake_q <= PW'(1)) begin
                        pwr_q <= ACPOC_PWR_RUN;
                    end
                end
                default: pwr_q <= ACPOC_PWR_RUN;
            endcase
        end
    end

    logic powered_dn;
    assign powered_dn = (pwr_q == ACPOC_PWR_DOWN);
    assign o_ref_on   = ~powered_dn;
    assign o_bias_on  = (pwr_q == ACPOC_PWR_RUN)
                      | (pwr_q == ACPOC_PWR_WAKE);
    assign o_awake    = (pwr_q == ACPOC_PWR_RUN);

    // Clock divider; clock stops in power-down and standby
    logic tick;
    logic raw_level;

    acpoc_clk_div #(
        .RW (3)
    ) u_div (
        .i_mclk     (i_mclk),
        .i_nrst     (i_nrst),
        .i_run      (~powered_dn & (pwr_q != ACPOC_PWR_STBY)),
        .i_ratio_m1 (div_q),
        .i_clk_in   (i_sample_clk),
        .o_tick     (tick),
        .o_level    (raw_level)
    );

    // Duty cycle stabilizer: period measure and lock
    logic [PW-1:0] phase_q;
    logic [PW-1:0] period_q;
    logic [PW-1:0] relock_q;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_q  <= '0;
            period_q <= '0;
        end else if (tick) begin
            phase_q  <= PW'(1);
            period_q <= phase_q;
        end else if (phase_q != '1) begin
            phase_q <= phase_q + 1'b1;
        end
    end

    // Any period change restarts the relock wait
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            relock_q <= '0;
            locked_q <= 1'b0;
        end else if (!dcs_en_q || (tick && phase_q != period_q)) begin
            relock_q <= '0;
            locked_q <= 1'b0;
        end else if (period_q > PW'(MAX_PERIOD)) begin
            locked_q <= 1'b0;
        end else if (relock_q < PW'(RELOCK_CYC)) begin
            relock_q <= relock_q + 1'b1;
        end else begin
            locked_q <= 1'b1;
        end
    end

    // Internal clock: regenerated falling edge when locked
    logic dcs_level_q;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            dcs_level_q <= 1'b0;
        end else if (tick) begin
            dcs_level_q <= 1'b1;
        end else if (phase_q >= (period_q >> 1)) begin
            dcs_level_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_int_clk <= 1'b0;
        end else if (dcs_en_q && locked_q) begin
            o_int_clk <= dcs_level_q;
        end else begin
            o_int_clk <= raw_level;
        end
    end

    // Sample pipeline; sample taken at each divider tick, one clock before the internal rising edge
    logic [DW-1:0] pipe_out;
    logic          ovr_out;

    acpoc_pipe_delay #(
        .W     (DW),
        .DEPTH (acpoc_pkg::LAT_NSR)
    ) u_data_pipe (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_adv  (tick),
        .i_tap  (nsr_q ? 4'(acpoc_pkg::LAT_NSR)
                       : 4'(acpoc_pkg::LAT_PLAIN)),
        .i_data (i_core_data),
        .o_data (pipe_out)
    );

    acpoc_pipe_delay #(
        .W     (1),
        .DEPTH (acpoc_pkg::LAT_OVR)
    ) u_ovr_pipe (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_adv  (tick),
        .i_tap  (4'(acpoc_pkg::LAT_OVR)),
        .i_data (i_core_ovr),
        .o_data (ovr_out)
    );

    // Output register updates on the divider tick, one clock before the internal edge rises
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= '0;
            o_ovr  <= 1'b0;
        end else if (tick) begin
            o_data <= encode(pipe_out, fmt_q);
            o_ovr  <= ovr_out;
        end
    end

    // Strobe follows the internal clock, one cycle behind so that
    // its rising edge lands after the data has settled
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_capture_strobe_out <= 1'b0;
        end else begin
            o_capture_strobe_out <= o_int_clk;
        end
    end

    // Tristate is a slow setting; no glitch-free handover implied
    assign o_data_oe   = ~powered_dn & ~tri_q;
    assign o_ovr_oe    = ~powered_dn;
    assign o_strobe_oe = ~powered_dn;
endmodule : acpoc_top

//--- dv/acpoc_top_checker.sv
// Pin-level assertions for the converter control top.
// Assumes one 100 MHz clock and the async low reset.
`timescale 1ns/1ps
module acpoc_top_checker #(
    parameter int DW = 11
) (
    // Clock and reset
    input wire logic          i_mclk,
    input wire logic          i_nrst,
    // Watched outputs
    input wire logic          o_int_clk,
    input wire logic          o_ref_on,
    input wire logic          o_bias_on,
    input wire logic          o_awake,
    input wire logic [DW-1:0] o_data,
    input wire logic          o_data_oe,
    input wire logic          o_ovr,
    input wire logic          o_ovr_oe,
    input wire logic          o_capture_strobe_out,
    input wire logic          o_strobe_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    chk_pd_data_hiz: assert property (!o_ref_on |-> !o_data_oe)
        else $error("data driven in power-down");
    chk_pd_side_hiz: assert property (!o_ref_on |-> !o_ovr_oe && !o_strobe_oe)
        else $error("flag or strobe driven in power-down");
    chk_bias_needs_ref: assert property (o_bias_on |-> o_ref_on)
        else $error("bias on without reference");
    chk_run_powered: assert property (o_awake |-> o_ref_on && o_bias_on)
        else $error("running with power off");
    chk_pd_clk_stop: assert property (!o_ref_on [*4] |-> $stable(o_int_clk))
        else $error("internal clock runs in power-down");
    chk_idle_data: assert property (!o_bias_on [*3] |-> $stable(o_data))
        else $error("data moved while asleep");
    chk_idle_ovr: assert property (!o_bias_on [*3] |-> $stable(o_ovr))
        else $error("overrange moved while asleep");
    chk_strobe_follow: assert property (o_capture_strobe_out == $past(o_int_clk))
        else $error("strobe does not trail clock");
endmodule : acpoc_top_checker

bind acpoc_top acpoc_top_checker #(.DW(DW)) chk_i (.i_mclk(i_mclk),
    .i_nrst(i_nrst), .o_int_clk(o_int_clk), .o_ref_on(o_ref_on),
    .o_bias_on(o_bias_on), .o_awake(o_awake), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_ovr(o_ovr), .o_ovr_oe(o_ovr_oe),
    .o_capture_strobe_out(o_capture_strobe_out),
    .o_strobe_oe(o_strobe_oe));

//--- dv/acpoc_capture_model.sv
// Receiving capture register on the data port.
// Assumes the strobe is the block's capture strobe output.
`timescale 1ns/1ps
module acpoc_capture_model #(
    parameter int DW = 11
) (
    input  wire logic          i_strobe,
    input  wire logic          i_oe,
    input  wire logic [DW-1:0] i_data,
    output logic      [DW-1:0] o_q
);
    // Released bus reads as noise, never the last value
    always_ff @(posedge i_strobe) begin
        o_q <= i_oe ? i_data : ~o_q;
    end
endmodule : acpoc_capture_model

//--- dv/tb.sv
// Self-checking bench for the converter control top.
// Serial writes and a 25 MHz sample clock off a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(n,a,b) begin n_checks++; if ((a) !== (b)) begin \
    err_total++; $display("BAD %s exp %0h got %0h", n, b, a); end end
module tb;
    logic        i_mclk, i_nrst, i_sample_clk, i_core_ovr, mark_o;
    logic        i_sclk, i_csb_n, i_sdio;
    logic [10:0] i_core_data, mark_d, cap_q, o_data;
    logic        o_int_clk, o_ref_on, o_bias_on, o_awake, o_strobe;
    logic        o_data_oe, o_ovr, o_ovr_oe, o_strobe_oe, o_sdio, o_sdio_oe;
    int          err_total, n_checks, n_rise;
    logic [7:0]  rx;
    acpoc_top #(.STBY_CYC(4)) DUT (.i_mclk(i_mclk), .i_nrst(i_nrst),
        .i_sample_clk(i_sample_clk), .i_core_data(i_core_data),
        .i_core_ovr(i_core_ovr), .i_sclk(i_sclk), .i_csb_n(i_csb_n),
        .i_sdio(i_sdio), .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe),
        .o_int_clk(o_int_clk),
        .o_ref_on(o_ref_on), .o_bias_on(o_bias_on), .o_awake(o_awake),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_ovr(o_ovr),
        .o_ovr_oe(o_ovr_oe), .o_capture_strobe_out(o_strobe),
        .o_strobe_oe(o_strobe_oe));
    acpoc_capture_model CAP (.i_strobe(o_strobe), .i_oe(o_data_oe),
        .i_data(o_data), .o_q(cap_q));
    initial begin
        i_mclk = 0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Sample clock 2 high, 2 low; marker rides one sample only
    initial begin
        i_sample_clk = 0; i_core_data = 0; i_core_ovr = 0;
        forever begin
            @(posedge i_mclk); #1 i_sample_clk = 1; n_rise++;
            i_core_data = mark_d; i_core_ovr = mark_o;
            mark_d = 0; mark_o = 0;
            repeat (2) @(posedge i_mclk); #1 i_sample_clk = 0;
            @(posedge i_mclk);
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task automatic tmo;
        err_total++; $display("BAD timeout"); conclude();
    endtask : tmo
    task automatic wr(input logic [12:0] a, input logic [7:0] d,
                      input logic r = 1'b0);
        logic [23:0] s;
        s = {r, 2'h0, a, d};
        @(posedge i_mclk); #1 i_csb_n = 0;
        for (int i = 23; i >= 0; i--) begin
            i_sdio = s[i]; repeat (2) @(posedge i_mclk);
            #1 rx = {rx[6:0], o_sdio & o_sdio_oe}; i_sclk = 1;
            repeat (2) @(posedge i_mclk); #1 i_sclk = 0;
        end
        repeat (2) @(posedge i_mclk); #1 i_csb_n = 1;
        repeat (3) @(posedge i_mclk);
    endtask : wr
    task automatic int_rise;
        int k;
        for (k = 0; k < 300 && o_int_clk !== 0; k++) @(posedge i_mclk);
        for (k = 0; k < 300 && o_int_clk !== 1; k++) @(posedge i_mclk);
        if (k == 300) tmo();
    endtask : int_rise
    task automatic ratio_chk;
        int n0;
        for (int r = 1; r <= 8; r++) begin
            wr(acpoc_pkg::ADR_CLOCK_DIV, 8'(r - 1));
            int_rise(); int_rise(); n0 = n_rise; int_rise();
            `CHK("ratio", n_rise - n0, r)
        end
        wr(acpoc_pkg::ADR_CLOCK_DIV, 8'h00);
    endtask : ratio_chk
    task automatic lat(input logic [1:0] f, input int ex);
        logic [10:0] v, e;
        int r0, k;
        v = 11'h5A3;
        e = (f == acpoc_pkg::FMT_TWOS) ? v ^ 11'h400 :
            (f == acpoc_pkg::FMT_GRAY) ? v ^ (v >> 1) : v;
        wr(acpoc_pkg::ADR_OUTPUT_MODE, {6'h00, f});
        mark_d = v; mark_o = 1;
        for (k = 0; k < 50 && mark_o; k++) @(posedge i_mclk);
        r0 = n_rise;
        for (k = 0; k < 400 && o_data !== e; k++) @(posedge i_mclk);
        if (k == 400) tmo();
        `CHK("latency", n_rise - r0, ex)
        if (ex == 10) `CHK("ovr", o_ovr, 1'b1)
        repeat (2) @(posedge i_mclk);
        `CHK("capture", cap_q, e)
    endtask : lat
    task automatic wake(input int d, output int t);
        wr(acpoc_pkg::ADR_POWER_MODE, 8'h01);
        repeat (d) @(posedge i_mclk);
        wr(acpoc_pkg::ADR_POWER_MODE, 8'h00);
        for (t = 0; t < 900 && o_awake !== 1; t++) @(posedge i_mclk);
        if (t == 900) tmo();
    endtask : wake
    task automatic pwr;
        int t1, t2;
        wr(acpoc_pkg::ADR_OUTPUT_MODE, 8'h10);
        `CHK("tri_data", o_data_oe, 1'b0)
        `CHK("tri_ovr", o_ovr_oe, 1'b1)
        wr(acpoc_pkg::ADR_OUTPUT_MODE, 8'h00);
        wr(acpoc_pkg::ADR_POWER_MODE, 8'h01);
        `CHK("pd_oe", {o_data_oe, o_strobe_oe}, 2'h0)
        `CHK("pd_pwr", {o_ref_on, o_bias_on}, 2'h0)
        wr(acpoc_pkg::ADR_POWER_MODE, 8'h02);
        `CHK("sb_pwr", {o_ref_on, o_bias_on, o_awake}, 3'h4)
        wake(100, t1);
        wake(2000, t2);
        `CHK("wake", t2 > t1, 1'b1)
        `CHK("run", {o_ref_on, o_bias_on, o_data_oe}, 3'h7)
    endtask : pwr
    initial begin
        i_nrst = 0; i_sclk = 0; i_csb_n = 1; i_sdio = 0;
        mark_d = 0; mark_o = 0; err_total = 0; n_checks = 0; n_rise = 0;
        repeat (3) @(posedge i_mclk);
        #1 i_nrst = 1;
        repeat (3) @(posedge i_mclk);
        wr(acpoc_pkg::ADR_CLOCK_CTRL, 8'h00, 1'b1);
        `CHK("dcs_rst", rx, 8'h00)
        wr(acpoc_pkg::ADR_CLOCK_CTRL, 8'h01);
        repeat (160) @(posedge i_mclk);
        wr(acpoc_pkg::ADR_STATUS, 8'h00, 1'b1);
        `CHK("slow_unlock", rx, 8'h02)
        ratio_chk();
        lat(acpoc_pkg::FMT_OFFSET, 10);
        lat(acpoc_pkg::FMT_TWOS, 10);
        lat(acpoc_pkg::FMT_GRAY, 10);
        wr(acpoc_pkg::ADR_NSR_CTRL, 8'h01);
        lat(acpoc_pkg::FMT_OFFSET, 13);
        wr(acpoc_pkg::ADR_NSR_CTRL, 8'h00);
        pwr();
        conclude();
    end
endmodule : tb
